// ---- pkg/eu_defines.svh ----
`ifndef EU_DEFINES_SVH
`define EU_DEFINES_SVH
// Register byte offsets
`define EU_OFS_STATUS    32'h0000_0000
`define EU_OFS_PENDING   32'h0000_0004
`define EU_OFS_CONTROL   32'h0000_0008
// Status word fields
`define EU_SW_T          15
`define EU_SW_S          13
`define EU_SW_MASK_HI    10
`define EU_SW_MASK_LO    8
`define EU_SW_RESET      16'h2700
`define EU_SW_WMASK      16'hA700
// Vector numbers
`define EU_VEC_RESET     8'h00
`define EU_VEC_BUS       8'h02
`define EU_VEC_ADDR      8'h03
`define EU_VEC_ILLEGAL   8'h04
`define EU_VEC_PRIV      8'h08
`define EU_VEC_TRACE     8'h09
`define EU_VEC_SPURIOUS  8'h18
`define EU_VEC_AUTO_BASE 8'h18
// Reset vector word addresses
`define EU_RST_SSP_HI    32'h0000_0000
`define EU_RST_SSP_LO    32'h0000_0002
`define EU_RST_PC_HI     32'h0000_0004
`define EU_RST_PC_LO     32'h0000_0006
// Reference classes on the function code lines
`define EU_FC_SUP_DATA   3'h5
`define EU_FC_SUP_PROG   3'h6
`define EU_FC_IACK       3'h7
// Request levels
`define EU_LVL_NONE      3'h0
`define EU_LVL_TWO       3'h2
`define EU_LVL_FIVE      3'h5
`define EU_LVL_NMI       3'h7
// Stack step and external reset pulse length
`define EU_STACK_STEP    32'h0000_0002
`define EU_RST_OUT_CYC   8'h10
`endif

// ---- pkg/eu_pkg.sv ----
package eu_pkg;
  // Sequencer states
  typedef enum logic [3:0] {
    ST_RUN, ST_RST_SSP_H, ST_RST_SSP_L, ST_RST_PC_H, ST_RST_PC_L, ST_IACK,
    ST_PUSH_PCL, ST_PUSH_PCH, ST_PUSH_SW, ST_VEC_H, ST_VEC_L, ST_FETCH, ST_HALT
  } eu_state_t;
  // One word request on the processor bus
  typedef struct packed {
    logic        valid;
    logic        we;
    logic [2:0]  fc;
    logic [31:0] addr;
    logic [15:0] wdata;
  } eu_mem_req_t;
endpackage

// ---- rtl/eu_exception_unit.sv ----
// What this block does
// - Reset, address or bus error aborts work; exception starts within two cycles.
// - Trace and interrupt wait for instruction end; illegal/privilege checked on next.
// - Trap, overflow trap, bounds check, zero divide come only from execution.
// - Abort group first, then between-instruction group, then instruction group.
// - Within the abort group: reset, then address error, then bus error.
// - Trace beats interrupt; interrupt beats illegal and privilege violation.
// - Trace taken first, then the interrupt, before any instruction resumes.
// - Reset drops work, sets supervisor, clears trace, mask to seven.
// - Reset saves nothing; loads stack pointer from address 0 and program pointer from address 4.
// - Software reset pulses the reset line only; execution continues.
// - Only request levels two, five and seven are recognised.
// - Three-bit mask; levels at or below it are inhibited.
// - Requests pend; looked at only between instructions, else postponed.
// - Accepting copies status, sets supervisor, clears trace, mask to level.
// - Vector read as interrupt acknowledge with level on address bus.
// - Autovector answer uses level vector; bus error answer uses spurious vector.
// - Push program pointer and status; pointer is the next unexecuted instruction.
// - Read new pointer high at vector address, low at plus 2, then fetch.
// - Mask never inhibits level seven.
// - Rise to seven raises an interrupt; lowering mask under seven does too.
// - Vector address is vector number times four, upper bits zero.
// - Autovector number is 24 plus the level.
`include "eu_defines.svh"
module eu_exception_unit (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [31:0]         wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output      logic [31:0]         wb_dat_o,
  output      logic                wb_ack_o,
  input  wire logic [2:0]          ipl_i,
  input  wire logic                boundary_i,
  input  wire logic                illegal_i,
  input  wire logic                priv_i,
  input  wire logic                trap_req_i,
  input  wire logic [7:0]          trap_vec_i,
  input  wire logic                addr_err_i,
  input  wire logic                bus_err_i,
  input  wire logic [31:0]         next_pp_i,
  output      eu_pkg::eu_mem_req_t mem_o,
  input  wire logic                mem_ack_i,
  input  wire logic                mem_berr_i,
  input  wire logic                autovector_request_in_i,
  input  wire logic [15:0]         mem_rdata_i,
  output      logic                core_hold_o,
  output      logic                core_abort_o,
  output      logic                core_start_o,
  output      logic                insn_valid_o,
  output      logic [15:0]         insn_o,
  output      logic [31:0]         program_pointer_o,
  output      logic [31:0]         supervisor_stack_pointer_o,
  output      logic [15:0]         status_word_o,
  output      logic                reset_out_o,
  output      logic                halted_o
);
  import eu_pkg::*;

  eu_state_t   state_reg, state_next;
  logic [15:0] sw_reg, sw_next, saved_sw_reg, saved_sw_next;
  logic [31:0] ssp_reg, ssp_next, pp_reg, pp_next;
  logic [7:0]  vec_reg, vec_next, trap_vec_reg, trap_vec_next, rst_cnt_reg, rst_cnt_next;
  logic [2:0]  lvl_reg, lvl_next, ipl_prev_reg;
  logic [15:0] insn_reg, insn_next;
  logic        between_reg, between_next, grp0_reg, grp0_next;
  logic        trace_pend_reg, trace_pend_next, ill_pend_reg, ill_pend_next;
  logic        priv_pend_reg, priv_pend_next, trap_pend_reg, trap_pend_next;
  logic        nmi_pend_reg, nmi_pend_next, nmi_clr;
  logic        start_reg, start_next, abort_reg, abort_next, ivalid_reg, ivalid_next;
  logic        ack_reg;
  logic [31:0] rdata_reg, rdata_next;

  // Request level filter and level-seven edge; unsupported codes count as no request
  wire [2:0] ipl_lvl  = (ipl_i == `EU_LVL_TWO || ipl_i == `EU_LVL_FIVE ||
                         ipl_i == `EU_LVL_NMI) ? ipl_i : `EU_LVL_NONE;
  wire       nmi_edge = (ipl_lvl == `EU_LVL_NMI) && (ipl_prev_reg != `EU_LVL_NMI);
  wire [2:0] mask     = sw_reg[`EU_SW_MASK_HI:`EU_SW_MASK_LO];
  // Plain comparison never passes seven, so the edge latch carries the non-maskable case
  wire       irq_take = (ipl_lvl > mask) || nmi_pend_reg;
  wire [2:0] irq_lvl  = nmi_pend_reg ? `EU_LVL_NMI : ipl_lvl;

  // Between-instruction decision, highest first
  wire       dec_trace = trace_pend_reg;
  wire       dec_irq   = ~trace_pend_reg & irq_take;
  wire       dec_any   = trace_pend_reg | irq_take | ill_pend_reg | priv_pend_reg |
                         trap_pend_reg;
  wire [7:0] dec_vec   = dec_trace    ? `EU_VEC_TRACE   :
                         ill_pend_reg  ? `EU_VEC_ILLEGAL :
                         priv_pend_reg ? `EU_VEC_PRIV    : trap_vec_reg;

  // Abort events from the core; address error outranks bus error
  wire       core_abort_ev = addr_err_i | bus_err_i;
  wire [7:0] abort_vec     = addr_err_i ? `EU_VEC_ADDR : `EU_VEC_BUS;
  wire       bus_done      = mem_ack_i | mem_berr_i;

  // Register bus decode; write lands on the edge where ack is seen
  wire wb_req     = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire wb_wr      = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
  wire hit_status = wb_adr_i == `EU_OFS_STATUS;
  wire hit_pend   = wb_adr_i == `EU_OFS_PENDING;
  wire hit_ctrl   = wb_adr_i == `EU_OFS_CONTROL;
  wire wr_status  = wb_wr & hit_status & wb_sel_i[1];
  wire wr_swrst   = wb_wr & hit_ctrl & wb_sel_i[0] & wb_dat_i[0];
  wire [31:0] rd_status = {16'h0000, sw_reg};
  wire [31:0] rd_pend   = {8'h00, vec_reg, 4'h0, 4'(state_reg), 2'b00,
                           (state_reg == ST_HALT), trace_pend_reg, nmi_pend_reg, ipl_lvl};
  wire [31:0] rd_ctrl   = {31'h0000_0000, reset_out_o};
  wire [31:0] rd_mux    = hit_status ? rd_status : hit_pend ? rd_pend :
                          hit_ctrl ? rd_ctrl : 32'h0000_0000;

  // Bus request built from the sequencer state
  wire [31:0] vec_addr = {22'h00_0000, vec_reg, 2'b00};
  wire [31:0] push_adr = ssp_reg - `EU_STACK_STEP;
  always_comb begin
    mem_o = '0;
    mem_o.valid = 1'b1;
    mem_o.fc    = `EU_FC_SUP_DATA;
    case (state_reg)
      ST_RST_SSP_H: begin
        mem_o.addr = `EU_RST_SSP_HI;
        mem_o.fc   = `EU_FC_SUP_PROG;
      end
      ST_RST_SSP_L: begin
        mem_o.addr = `EU_RST_SSP_LO;
        mem_o.fc   = `EU_FC_SUP_PROG;
      end
      ST_RST_PC_H: begin
        mem_o.addr = `EU_RST_PC_HI;
        mem_o.fc   = `EU_FC_SUP_PROG;
      end
      ST_RST_PC_L: begin
        mem_o.addr = `EU_RST_PC_LO;
        mem_o.fc   = `EU_FC_SUP_PROG;
      end
      ST_IACK: begin
        mem_o.addr = {28'h000_0000, lvl_reg, 1'b0};
        mem_o.fc   = `EU_FC_IACK;
      end
      ST_PUSH_PCL: begin
        mem_o.we    = 1'b1;
        mem_o.addr  = push_adr;
        mem_o.wdata = pp_reg[15:0];
      end
      ST_PUSH_PCH: begin
        mem_o.we    = 1'b1;
        mem_o.addr  = push_adr;
        mem_o.wdata = pp_reg[31:16];
      end
      ST_PUSH_SW: begin
        mem_o.we    = 1'b1;
        mem_o.addr  = push_adr;
        mem_o.wdata = saved_sw_reg;
      end
      ST_VEC_H: mem_o.addr = vec_addr;
      ST_VEC_L: mem_o.addr = vec_addr | 32'h0000_0002;
      ST_FETCH: begin
        mem_o.addr = pp_reg;
        mem_o.fc   = `EU_FC_SUP_PROG;
      end
      default: mem_o.valid = 1'b0;
    endcase
  end

  // Sequencer next state
  always_comb begin
    state_next      = state_reg;
    sw_next         = sw_reg;
    saved_sw_next   = saved_sw_reg;
    ssp_next        = ssp_reg;
    pp_next         = pp_reg;
    vec_next        = vec_reg;
    lvl_next        = lvl_reg;
    insn_next       = insn_reg;
    between_next    = between_reg;
    grp0_next       = grp0_reg;
    trace_pend_next = trace_pend_reg;
    ill_pend_next   = ill_pend_reg;
    priv_pend_next  = priv_pend_reg;
    trap_pend_next  = trap_pend_reg;
    trap_vec_next   = trap_vec_reg;
    nmi_clr         = 1'b0;
    start_next      = 1'b0;
    abort_next      = 1'b0;
    ivalid_next     = ivalid_reg;
    // Software status write; hardware entry below overrides it
    if (wr_status) begin
      sw_next = (sw_reg & ~`EU_SW_WMASK) | (wb_dat_i[15:0] & `EU_SW_WMASK);
    end
    // Instruction-caused traps latch only while an instruction runs
    if (state_reg == ST_RUN && !between_reg && trap_req_i) begin
      trap_pend_next = 1'b1;
      trap_vec_next  = trap_vec_i;
    end
    case (state_reg)
      ST_RUN: begin
        if (core_abort_ev) begin
          saved_sw_next   = sw_reg;
          sw_next[`EU_SW_S] = 1'b1;
          sw_next[`EU_SW_T] = 1'b0;
          vec_next        = abort_vec;
          pp_next         = next_pp_i;
          grp0_next       = 1'b1;
          between_next    = 1'b1;
          abort_next      = 1'b1;
          trace_pend_next = 1'b0;
          ill_pend_next   = 1'b0;
          priv_pend_next  = 1'b0;
          trap_pend_next  = 1'b0;
          state_next      = ST_PUSH_PCL;
        end else if (!between_reg) begin
          if (boundary_i) begin
            between_next    = 1'b1;
            pp_next         = next_pp_i;
            trace_pend_next = sw_reg[`EU_SW_T];
            ill_pend_next   = illegal_i;
            priv_pend_next  = priv_i;
            ivalid_next     = 1'b0;
          end
        end else if (dec_any) begin
          saved_sw_next     = sw_reg;
          sw_next[`EU_SW_S] = 1'b1;
          sw_next[`EU_SW_T] = 1'b0;
          // Handler code runs next, so an opcode check on the old stream is stale
          ill_pend_next     = 1'b0;
          priv_pend_next    = 1'b0;
          if (dec_irq) begin
            sw_next[`EU_SW_MASK_HI:`EU_SW_MASK_LO] = irq_lvl;
            lvl_next   = irq_lvl;
            nmi_clr    = (irq_lvl == `EU_LVL_NMI);
            state_next = ST_IACK;
          end else begin
            vec_next        = dec_vec;
            trace_pend_next = 1'b0;
            if (!dec_trace && !ill_pend_reg && !priv_pend_reg) begin
              trap_pend_next = 1'b0;
            end
            state_next = ST_PUSH_PCL;
          end
        end else begin
          between_next = 1'b0;
          start_next   = 1'b1;
        end
      end
      ST_IACK: begin
        if (mem_berr_i) begin
          vec_next   = `EU_VEC_SPURIOUS;
          state_next = ST_PUSH_PCL;
        end else if (autovector_request_in_i) begin
          vec_next   = `EU_VEC_AUTO_BASE + {5'h00, lvl_reg};
          state_next = ST_PUSH_PCL;
        end else if (mem_ack_i) begin
          vec_next   = mem_rdata_i[7:0];
          state_next = ST_PUSH_PCL;
        end
      end
      ST_HALT: state_next = ST_HALT;
      default: begin
        if (mem_berr_i) begin
          if (grp0_reg) begin
            state_next = ST_HALT;
          end else begin
            saved_sw_next     = sw_reg;
            sw_next[`EU_SW_S] = 1'b1;
            sw_next[`EU_SW_T] = 1'b0;
            vec_next          = `EU_VEC_BUS;
            grp0_next         = 1'b1;
            state_next        = ST_PUSH_PCL;
          end
        end else if (mem_ack_i) begin
          case (state_reg)
            ST_RST_SSP_H: begin
              ssp_next[31:16] = mem_rdata_i;
              state_next      = ST_RST_SSP_L;
            end
            ST_RST_SSP_L: begin
              ssp_next[15:0] = mem_rdata_i;
              state_next     = ST_RST_PC_H;
            end
            ST_RST_PC_H: begin
              pp_next[31:16] = mem_rdata_i;
              state_next     = ST_RST_PC_L;
            end
            ST_RST_PC_L: begin
              pp_next[15:0] = mem_rdata_i;
              state_next    = ST_FETCH;
            end
            ST_PUSH_PCL: begin
              ssp_next   = push_adr;
              state_next = ST_PUSH_PCH;
            end
            ST_PUSH_PCH: begin
              ssp_next   = push_adr;
              state_next = ST_PUSH_SW;
            end
            ST_PUSH_SW: begin
              ssp_next   = push_adr;
              state_next = ST_VEC_H;
            end
            ST_VEC_H: begin
              pp_next[31:16] = mem_rdata_i;
              state_next     = ST_VEC_L;
            end
            ST_VEC_L: begin
              pp_next[15:0] = mem_rdata_i;
              state_next    = ST_FETCH;
            end
            ST_FETCH: begin
              insn_next    = mem_rdata_i;
              ivalid_next  = 1'b1;
              grp0_next    = 1'b0;
              between_next = 1'b1;
              state_next   = ST_RUN;
            end
            default: state_next = ST_HALT;
          endcase
        end
      end
    endcase
  end

  // Sequencer and status registers; reset starts the vector load directly
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg      <= ST_RST_SSP_H;
      sw_reg         <= `EU_SW_RESET;
      saved_sw_reg   <= 16'h0000;
      ssp_reg        <= 32'h0000_0000;
      pp_reg         <= 32'h0000_0000;
      vec_reg        <= `EU_VEC_RESET;
      lvl_reg        <= `EU_LVL_NONE;
      insn_reg       <= 16'h0000;
      between_reg    <= 1'b0;
      grp0_reg       <= 1'b1;
      trace_pend_reg <= 1'b0;
      ill_pend_reg   <= 1'b0;
      priv_pend_reg  <= 1'b0;
      trap_pend_reg  <= 1'b0;
      trap_vec_reg   <= 8'h00;
      start_reg      <= 1'b0;
      abort_reg      <= 1'b0;
      ivalid_reg     <= 1'b0;
    end else begin
      state_reg      <= state_next;
      sw_reg         <= sw_next;
      saved_sw_reg   <= saved_sw_next;
      ssp_reg        <= ssp_next;
      pp_reg         <= pp_next;
      vec_reg        <= vec_next;
      lvl_reg        <= lvl_next;
      insn_reg       <= insn_next;
      between_reg    <= between_next;
      grp0_reg       <= grp0_next;
      trace_pend_reg <= trace_pend_next;
      ill_pend_reg   <= ill_pend_next;
      priv_pend_reg  <= priv_pend_next;
      trap_pend_reg  <= trap_pend_next;
      trap_vec_reg   <= trap_vec_next;
      start_reg      <= start_next;
      abort_reg      <= abort_next;
      ivalid_reg     <= ivalid_next;
    end
  end

  // Level-seven latch; a new edge wins over the clear of the previous one
  assign nmi_pend_next = nmi_edge | (nmi_pend_reg & ~nmi_clr);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ipl_prev_reg <= `EU_LVL_NONE;
      nmi_pend_reg <= 1'b0;
    end else begin
      ipl_prev_reg <= ipl_lvl;
      nmi_pend_reg <= nmi_pend_next;
    end
  end

  // External reset pulse from software; no vector load, core keeps running
  assign rst_cnt_next = wr_swrst ? `EU_RST_OUT_CYC :
                        (rst_cnt_reg != 8'h00) ? rst_cnt_reg - 8'h01 : 8'h00;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_cnt_reg <= 8'h00;
      reset_out_o <= 1'b0;
    end else begin
      rst_cnt_reg <= rst_cnt_next;
      reset_out_o <= rst_cnt_next != 8'h00;
    end
  end

  // Bus slave: one wait state, ack for one cycle, unmapped reads zero
  assign rdata_next = wb_req ? rd_mux : rdata_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= wb_req;
      rdata_reg <= rdata_next;
    end
  end

  // Outputs
  assign wb_ack_o                   = ack_reg;
  assign wb_dat_o                   = rdata_reg;
  assign core_hold_o                = (state_reg != ST_RUN) | between_reg;
  assign core_abort_o               = abort_reg;
  assign core_start_o               = start_reg;
  assign insn_valid_o               = ivalid_reg;
  assign insn_o                     = insn_reg;
  assign program_pointer_o          = pp_reg;
  assign supervisor_stack_pointer_o = ssp_reg;
  assign status_word_o              = sw_reg;
  assign halted_o                   = state_reg == ST_HALT;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire in_dec = (state_reg == ST_RUN) && between_reg && !core_abort_ev;

  a_abort_two_cycles: assert property (
    (state_reg == ST_RUN && core_abort_ev) |=> (state_reg == ST_PUSH_PCL) ##1 1'b1
  ) else $error("abort did not start exception processing");
  a_abort_rank: assert property (
    (state_reg == ST_RUN && addr_err_i && bus_err_i) |=> vec_reg == `EU_VEC_ADDR
  ) else $error("bus error taken over address error");
  a_trace_first: assert property (
    (in_dec && trace_pend_reg && irq_take) |=> (vec_reg == `EU_VEC_TRACE && !ivalid_reg)
  ) else $error("interrupt taken before trace");
  a_group_order: assert property (
    (in_dec && irq_take && !trace_pend_reg && trap_pend_reg) |=> state_reg == ST_IACK
  ) else $error("instruction trap taken before interrupt");
  a_mask_update: assert property (
    (in_dec && dec_irq) |=> (mask == $past(irq_lvl) && sw_reg[`EU_SW_S] && !sw_reg[`EU_SW_T])
  ) else $error("mask not set to accepted level");
  a_reset_init: assert property (disable iff (1'b0)
    rst_i |=> (sw_reg == `EU_SW_RESET && state_reg == ST_RST_SSP_H)
  ) else $error("reset did not initialise status");
  a_autovector: assert property (
    (state_reg == ST_IACK && autovector_request_in_i && !mem_berr_i)
      |=> vec_reg == `EU_VEC_AUTO_BASE + {5'h00, lvl_reg}
  ) else $error("autovector number wrong");
  a_spurious_vec: assert property (
    (state_reg == ST_IACK && mem_berr_i) |=> (vec_reg == `EU_VEC_SPURIOUS && state_reg == ST_PUSH_PCL)
  ) else $error("spurious vector not used");
  a_vector_addr: assert property (
    (state_reg == ST_VEC_H) |-> (mem_o.addr[31:10] == 22'h00_0000 && mem_o.addr[9:2] == vec_reg)
  ) else $error("vector address not four times number");
  a_masked_wait: assert property (
    (in_dec && !dec_any) |=> (core_start_o && !between_reg)
  ) else $error("masked request held up the next instruction");
  a_nmi_edge: assert property (
    (nmi_edge && mask == `EU_LVL_NMI) |=> irq_take
  ) else $error("level seven inhibited by mask");

  c_trace_then_irq: cover property (in_dec && trace_pend_reg && irq_take);
  c_spurious:       cover property (state_reg == ST_IACK && mem_berr_i);
  c_autovector:     cover property (state_reg == ST_IACK && autovector_request_in_i);
  c_halt:           cover property (state_reg == ST_HALT);
endmodule

// ---- verif/eu_exception_unit_tb.sv ----
`include "eu_defines.svh"
module eu_exception_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import eu_pkg::*;
  logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic        boundary_i = 0, addr_err_i = 0, bus_err_i = 0, m_ack, m_berr, m_av;
  logic        illegal_i = 0, priv_i = 0, trap_req_i = 0, core_abort_o, core_start_o, reset_out_o;
  logic        core_hold_o, insn_valid_o, halted_o;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [7:0]  trap_vec_i = 8'h00, vec = 8'h00;
  logic [1:0]  mode = 2'd0;
  logic [2:0]  ipl = 3'd0;
  logic [15:0] m_rd, status_word_o, wq[$];
  logic [31:0] wb_adr_i = '0, wb_dat_i = '0, wb_dat_o, next_pp_i = '0, q, pp_n, iack_a, vq[$];
  logic [31:0] program_pointer_o, supervisor_stack_pointer_o;
  eu_mem_req_t mem_o;
  int          err_total = 0, n_checks = 0, iack_n = 0, cyc_n = 0;
  eu_exception_unit dut_u (.*, .ipl_i(ipl), .mem_ack_i(m_ack), .mem_berr_i(m_berr),
    .autovector_request_in_i(m_av), .mem_rdata_i(m_rd), .insn_o());
  eu_mem_model mem_u (.clk_i(clk_i), .rst_i(rst_i), .mem_i(mem_o), .mode_i(mode),
    .vec_i(vec), .ack_o(m_ack), .berr_o(m_berr), .av_o(m_av), .rdata_o(m_rd));
  always #20 clk_i = ~clk_i;
  // Bus monitor; also cuts a hang short
  always @(posedge clk_i) begin
    cyc_n++;
    if (mem_o.valid && (m_ack || m_berr || m_av)) begin
      if (mem_o.fc == `EU_FC_IACK) iack_a = mem_o.addr;
      if (mem_o.fc == `EU_FC_IACK) iack_n++;
      if (mem_o.we) wq.push_back(mem_o.wdata);
      if (!mem_o.we && mem_o.fc == `EU_FC_SUP_DATA) vq.push_back(mem_o.addr);
    end
    // Timeout last, so nothing runs after the verdict
    if (cyc_n == 20000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic end_sim;
    if (err_total == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  // Classic cycle; holds everything until ack is sampled high
  task automatic wb(input logic w, input logic [31:0] a, d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic wstart;
    for (int i = 0; i < 400 && core_start_o !== 1'b1; i++) @(posedge clk_i);
    chk(core_start_o, 1'b1);
    chk(core_hold_o, 1'b0);
    chk(insn_valid_o, 1'b1);
  endtask
  // Handler address the model stores at vector v: low word read at v*4+2
  function automatic logic [31:0] exp_pp(input logic [7:0] v);
    return {16'h0000, v[5:0], 2'b10, 8'h00};
  endfunction
  task automatic irq(input logic [2:0] l, m, input logic [1:0] md, input logic [7:0] v,
                     input logic t);
    logic       tk;
    logic [7:0] ev;
    tk = (l == 3'd2 || l == 3'd5 || l == 3'd7) && (l > m || l == 3'd7);
    ev = md == 2'd0 ? v : (md == 2'd1 ? 8'd24 + 8'(l) : 8'd24);
    wb(1'b1, 32'h0, {16'h0000, t, 2'b01, 2'b00, m, 8'h00});
    wb(1'b0, 32'h0, 32'h0);
    chk(q[15:0], {t, 2'b01, 2'b00, m, 8'h00});
    iack_n = 0;
    wq.delete();
    vq.delete();
    mode <= md;
    vec <= v;
    ipl <= l;
    repeat (3) @(posedge clk_i);
    pp_n = $urandom & 32'h00FF_FFFE;
    next_pp_i <= pp_n;
    boundary_i <= 1'b1;
    @(posedge clk_i);
    boundary_i <= 1'b0;
    if (tk) begin
      wstart();
      chk(program_pointer_o, exp_pp(ev));
      chk(status_word_o, {3'b001, 2'b00, l, 8'h00});
      chk(iack_a, {28'h0, l, 1'b0});
      if (t) chk(vq[0], 32'h24);
      else chk(wq[0], pp_n[15:0]);
    end else begin
      repeat (20) @(posedge clk_i);
      chk(iack_n, 0);
      chk(insn_valid_o, 1'b0);
    end
    ipl <= 3'd0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic ab(input logic a, b);
    {addr_err_i, bus_err_i} <= {a, b};
    @(posedge clk_i);
    {addr_err_i, bus_err_i} <= 2'b00;
    for (int i = 0; i < 2 && core_abort_o !== 1'b1; i++) @(posedge clk_i);
    chk(core_abort_o, 1'b1);
    wstart();
    chk(program_pointer_o, exp_pp(a ? 8'd3 : 8'd2));
  endtask
  initial begin
    pp_n = $urandom(32'hefc8e3d8);
    repeat (10) @(posedge clk_i);
    chk(mem_o.addr, 32'h0);
    chk(mem_o.fc, `EU_FC_SUP_PROG);
    rst_i <= 1'b0;
    wstart();
    chk(supervisor_stack_pointer_o, 32'h0200);
    chk(program_pointer_o, 32'h0600);
    chk(status_word_o, 16'h2700);
    wb(1'b0, 32'h10, 32'h0);
    chk(q, 32'h0);
    irq(3'd5, 3'd2, 2'd1, 8'h00, 1'b0);
    irq(3'd2, 3'd0, 2'd0, 8'h0F, 1'b0);
    irq(3'd7, 3'd7, 2'd2, 8'h00, 1'b0);
    irq(3'd5, 3'd5, 2'd0, 8'h40, 1'b0);
    irq(3'd3, 3'd0, 2'd0, 8'h40, 1'b0);
    irq(3'd5, 3'd0, 2'd1, 8'h00, 1'b1);
    repeat (8) irq(3'($urandom_range(7)), 3'($urandom_range(7)), 2'($urandom_range(2)),
                   8'($urandom_range(64, 255)), 1'b0);
    // Trap during execution, then an illegal or privileged next opcode
    trap_vec_i <= 8'($urandom_range(32, 47));
    trap_req_i <= 1'b1;
    @(posedge clk_i);
    trap_req_i <= 1'b0;
    vq.delete();
    pp_n = $urandom;
    {illegal_i, priv_i, boundary_i} <= {pp_n[0], ~pp_n[0], 1'b1};
    @(posedge clk_i);
    {illegal_i, priv_i, boundary_i} <= 3'b000;
    wstart();
    chk(vq[0], pp_n[0] ? 32'h10 : 32'h20);
    chk(vq[2], {22'h0, trap_vec_i, 2'b00});
    ab(1'b0, 1'b1);
    ab(1'b1, 1'b1);
    // Bus error while stacking an abort halts until reset
    mode <= 2'd3;
    addr_err_i <= 1'b1;
    @(posedge clk_i);
    addr_err_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    chk(halted_o, 1'b1);
    chk(core_hold_o, 1'b1);
    rst_i <= 1'b1;
    mode <= 2'd0;
    repeat (2) @(posedge clk_i);
    chk(status_word_o, 16'h2700);
    rst_i <= 1'b0;
    wstart();
    chk(halted_o, 1'b0);
    chk(program_pointer_o, 32'h0600);
    wb(1'b1, 32'h8, 32'h1);
    @(posedge clk_i);
    chk(reset_out_o, 1'b1);
    repeat (`EU_RST_OUT_CYC - 1) @(posedge clk_i);
    chk(reset_out_o, 1'b1);
    @(posedge clk_i);
    chk(reset_out_o, 1'b0);
    end_sim();
  end
endmodule

// ---- verif/eu_mem_model.sv ----
`include "eu_defines.svh"
module eu_mem_model
  import eu_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire eu_mem_req_t mem_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic [7:0]  vec_i,
  output logic             ack_o,
  output logic             berr_o,
  output logic             av_o,
  output logic [15:0]      rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_q;
  logic       iack;
  assign iack = mem_i.fc == `EU_FC_IACK;
  initial {ack_o, berr_o, av_o, rdata_o, wait_q} = '0;
  // Answers after 0..3 cycles; released data lines toggle so stale data never matches
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    berr_o <= 1'b0;
    av_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (rst_i || !mem_i.valid || ack_o || berr_o || av_o) begin
      wait_q <= 2'($urandom_range(3));
    end else if (wait_q != 2'd0) begin
      wait_q <= wait_q - 2'd1;
    end else if (iack && mode_i == 2'd1) begin
      av_o <= 1'b1;
    end else if (mode_i == 2'd3 || (iack && mode_i == 2'd2)) begin
      berr_o <= 1'b1;
    end else begin
      ack_o <= 1'b1;
      rdata_o <= iack ? {8'h00, vec_i} : {mem_i.addr[1] ? mem_i.addr[7:0] : 8'h00, 8'h00};
    end
  end
endmodule
